/* File: hw/ram_monitor.sv */
// remote alarm monitor: alarm capture, message sequencing, status led and wishbone registers
`timescale 1ns/1ps
//
// Functional notes
// RQ1 - when an alarm is recognised the unit sends exactly one message for it to the master.
// RQ2 - after a message is sent it is not repeated, whether the alarm clears or stays.
// RQ3 - a new message for an alarm needs the alarm absent without a break for one second first.
// RQ4 - the status led is green while no alarm of any kind is active.
// RQ5 - the led is orange for external alarms, optical receive and level-control alarms.
// RQ6 - the led is red for 28V or 12V supply, temperature and fan alarms.
// RQ7 - separate flags exist for optical receive, optical transmit and autolevelling.
// RQ8 - one flag per downlink amplifier covers current too high or too low.
// RQ9 - separate downlink and uplink level-control alarm flags exist.
// RQ10 - flags exist for temperature, internal bus, 12V, 28V, mains supply and fan.
// RQ11 - four external alarm inputs each have their own flag.
// RQ12 - the master can read the current state of every alarm flag at any time.
// RQ13 - with both red and orange alarms active the led shows red.
// RQ14 - the one-second gap is timed on the device clock and restarts when the alarm returns.
//
module ram_monitor #(
  parameter int unsigned QUIET_CYCLES = ram_pkg::QUIET_CYCLES
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // built-in test alarm pins, active high
  input  wire logic        opt_rx_fail_i,
  input  wire logic        opt_tx_fail_i,
  input  wire logic        autolevel_i,
  input  wire logic [2:0]  amp_current_i,
  input  wire logic        alc_downlink_i,
  input  wire logic        alc_uplink_i,
  input  wire logic        temp_i,
  input  wire logic        bus_fail_i,
  input  wire logic        psu_12v_i,
  input  wire logic        psu_28v_i,
  input  wire logic        psu_mains_i,
  input  wire logic        fan_i,
  input  wire logic [3:0]  ext_alarm_i,
  // alarm messages towards the optical link
  output logic             msg_valid_o,
  output logic      [4:0]  msg_code_o,
  input  wire logic        msg_ready_i,
  // status led and interrupt
  output logic             led_green_o,
  output logic             led_orange_o,
  output logic             led_red_o,
  output logic             irq_o
);

  localparam int unsigned N = ram_pkg::N_ALARM;
  localparam int unsigned CW = ram_pkg::CODE_W;

  // ****************************************
  // functions
  // ****************************************

  // expand byte enables into a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : lane_mask

  // index of the lowest set bit; zero when none is set
  function automatic logic [CW-1:0] first_set(input logic [N-1:0] v);
    first_set = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (v[i])
        first_set = CW'(i);
    end
  endfunction : first_set

  // ****************************************
  // alarm capture
  // ****************************************

  logic [N-1:0] raw_alarm;
  logic [N-1:0] sync1_q;
  logic [N-1:0] sync2_q;

  // one flag per documented alarm condition
  assign raw_alarm[ram_pkg::BIT_OPT_RX]  = opt_rx_fail_i;   // RQ7
  assign raw_alarm[ram_pkg::BIT_OPT_TX]  = opt_tx_fail_i;   // RQ7
  assign raw_alarm[ram_pkg::BIT_AUTOLVL] = autolevel_i;     // RQ7
  assign raw_alarm[ram_pkg::BIT_AMP+2:ram_pkg::BIT_AMP] = amp_current_i;  // RQ8
  assign raw_alarm[ram_pkg::BIT_ALC_DN]  = alc_downlink_i;  // RQ9
  assign raw_alarm[ram_pkg::BIT_ALC_UP]  = alc_uplink_i;    // RQ9
  assign raw_alarm[ram_pkg::BIT_TEMP]    = temp_i;          // RQ10
  assign raw_alarm[ram_pkg::BIT_BUS]     = bus_fail_i;      // RQ10
  assign raw_alarm[ram_pkg::BIT_PSU12]   = psu_12v_i;       // RQ10
  assign raw_alarm[ram_pkg::BIT_PSU28]   = psu_28v_i;       // RQ10
  assign raw_alarm[ram_pkg::BIT_MAINS]   = psu_mains_i;     // RQ10
  assign raw_alarm[ram_pkg::BIT_FAN]     = fan_i;           // RQ10
  assign raw_alarm[ram_pkg::BIT_EXT+3:ram_pkg::BIT_EXT] = ext_alarm_i;    // RQ11

  // two-stage synchroniser; pins are asynchronous to clk_i
  // a pulse shorter than one clock may be missed; alarm sources are slow levels
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= raw_alarm;
      sync2_q <= sync1_q;
    end
  end

  // ****************************************
  // message qualification
  // ****************************************

  logic [N-1:0] fire;

  // each alarm has its own gap timer so one noisy input cannot hold off another
  for (genvar g = 0; g < N; g++)
  begin : g_qual
    ram_qualifier #(
      .CNT_W       (ram_pkg::QUIET_CNT_W),
      .HOLD_CYCLES (QUIET_CYCLES)
    ) u_qual (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .alarm_i (sync2_q[g]),
      .fire_o  (fire[g])
    );
  end

  // ****************************************
  // wishbone decode
  // ****************************************

  logic          ack_q;
  logic [31:0]   dat_q;
  logic [N-1:0]  event_q;
  logic [N-1:0]  event_d;
  logic [N-1:0]  mask_q;
  logic [N-1:0]  mask_d;
  logic          msg_en_q;
  logic          msg_en_d;
  ram_pkg::ram_led_t led_q;
  ram_pkg::ram_led_t led_d;

  wire logic        bus_req;
  wire logic        bus_wr;
  wire logic [31:0] wmask;
  wire logic [31:0] wbits;
  wire logic        hit_event;
  wire logic        hit_mask;
  wire logic        hit_ctrl;
  logic      [31:0] rd_data;

  // a request is answered one cycle after it is seen; ack_q blocks a second answer
  assign bus_req   = wb_cyc_i & wb_stb_i & ~ack_q;
  // writes land on the edge where the master samples ack, so a master that
  // abandons a cycle before the answer leaves the registers untouched
  assign bus_wr    = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
  assign wmask     = lane_mask(wb_sel_i);
  assign wbits     = wb_dat_i & wmask;
  assign hit_event = bus_wr & (wb_adr_i == ram_pkg::ADR_EVENT);
  assign hit_mask  = bus_wr & (wb_adr_i == ram_pkg::ADR_MASK);
  assign hit_ctrl  = bus_wr & (wb_adr_i == ram_pkg::ADR_CTRL);

  // read mux; unmapped addresses answer with zero
  always_comb
  begin
    case (wb_adr_i)
      ram_pkg::ADR_STATUS: rd_data = {{(32-N){1'b0}}, sync2_q};  // RQ12
      ram_pkg::ADR_EVENT:  rd_data = {{(32-N){1'b0}}, event_q};
      ram_pkg::ADR_MASK:   rd_data = {{(32-N){1'b0}}, mask_q};
      ram_pkg::ADR_CTRL:   rd_data = {31'h00000000, msg_en_q};
      ram_pkg::ADR_LED:    rd_data = {30'h00000000, led_q};
      default:             rd_data = 32'h00000000;
    endcase
  end

  // ****************************************
  // register next values
  // ****************************************

  // sticky events: a new message event wins over a write-one clear in the same cycle
  assign event_d  = (event_q & ~(hit_event ? wbits[N-1:0] : '0)) | fire;
  assign mask_d   = hit_mask ? ((mask_q & ~wmask[N-1:0]) | wbits[N-1:0]) : mask_q;
  assign msg_en_d = (hit_ctrl & wmask[ram_pkg::CTRL_MSG_EN_BIT]) ?
                    wb_dat_i[ram_pkg::CTRL_MSG_EN_BIT] : msg_en_q;

  // bus answer and software registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q    <= 1'b0;
      dat_q    <= 32'h00000000;
      event_q  <= ram_pkg::EVENT_RST;
      mask_q   <= ram_pkg::MASK_RST;
      msg_en_q <= ram_pkg::CTRL_MSG_EN_RST;
    end
    else
    begin
      ack_q    <= bus_req;
      dat_q    <= bus_req ? rd_data : 32'h00000000;
      event_q  <= event_d;
      mask_q   <= mask_d;
      msg_en_q <= msg_en_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ****************************************
  // message sequencing
  // ****************************************

  logic [N-1:0]  pend_q;
  logic [N-1:0]  pend_d;
  logic          mvalid_q;
  logic [CW-1:0] mcode_q;

  wire logic          out_free;
  wire logic          load;
  wire logic [CW-1:0] pick;
  wire logic [N-1:0]  take;

  // several alarms may fire together; they queue as pending bits and leave lowest first
  assign out_free = ~mvalid_q | msg_ready_i;
  assign load     = out_free & (|pend_q);
  assign pick     = first_set(pend_q);
  assign take     = load ? (N'(1) << pick) : '0;
  // disabling messages drops new requests; the qualifier still counts them as reported
  assign pend_d   = (pend_q & ~take) | (fire & {N{msg_en_q}});  // RQ1

  // one message per qualified alarm, held until the link takes it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pend_q   <= '0;
      mvalid_q <= 1'b0;
      mcode_q  <= '0;
    end
    else
    begin
      pend_q <= pend_d;
      if (out_free)
      begin
        mvalid_q <= load;   // RQ1
        mcode_q  <= load ? pick : mcode_q;
      end
    end
  end

  assign msg_valid_o = mvalid_q;
  assign msg_code_o  = mcode_q;

  // ****************************************
  // status led and interrupt
  // ****************************************

  wire logic any_alarm;
  wire logic red_alarm;
  logic      irq_q;
  logic      led_green_q;
  logic      led_orange_q;
  logic      led_red_q;

  assign any_alarm = |sync2_q;
  assign red_alarm = |(sync2_q & ram_pkg::RED_GROUP);  // RQ6

  // red outranks orange; alarms in neither group also show orange
  always_comb
  begin
    if (red_alarm)
      led_d = ram_pkg::LED_RED;      // RQ13
    else if (any_alarm)
      led_d = ram_pkg::LED_ORANGE;   // RQ5
    else
      led_d = ram_pkg::LED_GREEN;    // RQ4
  end

  // led colour and interrupt line registered so outputs come from flops
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      led_q <= ram_pkg::LED_GREEN;
      irq_q <= 1'b0;
    end
    else
    begin
      led_q <= led_d;
      irq_q <= |(event_d & mask_d);
    end
  end

  // one flop per lamp so each led pin comes straight from a register and never glitches on decode
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      led_green_q  <= 1'b1;
      led_orange_q <= 1'b0;
      led_red_q    <= 1'b0;
    end
    else
    begin
      led_green_q  <= (led_d == ram_pkg::LED_GREEN);   // RQ4
      led_orange_q <= (led_d == ram_pkg::LED_ORANGE);  // RQ5
      led_red_q    <= (led_d == ram_pkg::LED_RED);     // RQ6
    end
  end

  assign led_green_o  = led_green_q;
  assign led_orange_o = led_orange_q;
  assign led_red_o    = led_red_q;
  assign irq_o        = irq_q;

endmodule : ram_monitor

/* File: hw/ram_qualifier.sv */
// per-alarm message qualifier with the quiet-interval counter
`timescale 1ns/1ps
module ram_qualifier #(
  parameter int unsigned CNT_W       = ram_pkg::QUIET_CNT_W,
  parameter int unsigned HOLD_CYCLES = ram_pkg::QUIET_CYCLES
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // synchronised alarm level
  input  wire logic alarm_i,
  // one-cycle request for a message
  output logic      fire_o
);

  ram_pkg::ram_qstate_t state_q;
  ram_pkg::ram_qstate_t state_d;
  logic [CNT_W-1:0]     cnt_q;
  logic [CNT_W-1:0]     cnt_d;
  logic                 fire_d;
  wire logic            cnt_done;

  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(HOLD_CYCLES - 1);

  assign cnt_done = (cnt_q == CNT_LAST);

  // armed: first sight of the alarm fires once; quiet: wait for a clean gap
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    fire_d  = 1'b0;
    case (state_q)
      ram_pkg::QS_ARMED:
      begin
        cnt_d = '0;
        if (alarm_i)
        begin
          fire_d  = 1'b1;               // RQ1
          state_d = ram_pkg::QS_QUIET;  // RQ2
        end
      end
      ram_pkg::QS_QUIET:
      begin
        if (alarm_i)
          cnt_d = '0;                   // RQ14
        else if (cnt_done)
        begin
          cnt_d   = '0;
          state_d = ram_pkg::QS_ARMED;  // RQ3
        end
        else
          cnt_d = cnt_q + CNT_W'(1);    // RQ14
      end
      default:
      begin
        state_d = ram_pkg::QS_ARMED;
        cnt_d   = '0;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= ram_pkg::QS_ARMED;
      cnt_q   <= '0;
      fire_o  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      fire_o  <= fire_d;
    end
  end

endmodule : ram_qualifier

/* File: pkg/ram_pkg.sv */
// shared constants and types of the remote alarm monitor
package ram_pkg;

  // ****************************************
  // alarm vector layout
  // ****************************************
  localparam int unsigned N_ALARM     = 18;
  localparam int unsigned CODE_W      = 5;
  localparam int unsigned BIT_OPT_RX  = 0;
  localparam int unsigned BIT_OPT_TX  = 1;
  localparam int unsigned BIT_AUTOLVL = 2;
  localparam int unsigned BIT_AMP     = 3;   // three amplifiers, bits 3..5
  localparam int unsigned BIT_ALC_DN  = 6;
  localparam int unsigned BIT_ALC_UP  = 7;
  localparam int unsigned BIT_TEMP    = 8;
  localparam int unsigned BIT_BUS     = 9;
  localparam int unsigned BIT_PSU12   = 10;
  localparam int unsigned BIT_PSU28   = 11;
  localparam int unsigned BIT_MAINS   = 12;
  localparam int unsigned BIT_FAN     = 13;
  localparam int unsigned BIT_EXT     = 14;  // four external inputs, bits 14..17

  // alarms caused by the unit itself, and those caused outside it
  localparam logic [N_ALARM-1:0] RED_GROUP    = 18'h02D00;
  localparam logic [N_ALARM-1:0] ORANGE_GROUP = 18'h3C0C1;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam int unsigned ADR_W      = 8;
  localparam logic [7:0]  ADR_STATUS = 8'h00;
  localparam logic [7:0]  ADR_EVENT  = 8'h04;
  localparam logic [7:0]  ADR_MASK   = 8'h08;
  localparam logic [7:0]  ADR_CTRL   = 8'h0C;
  localparam logic [7:0]  ADR_LED    = 8'h10;
  localparam logic [N_ALARM-1:0] MASK_RST = 18'h00000;
  localparam logic [N_ALARM-1:0] EVENT_RST = 18'h00000;
  localparam logic        CTRL_MSG_EN_RST = 1'b1;
  localparam int unsigned CTRL_MSG_EN_BIT = 0;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned QUIET_TIME_MS = 1000;
  localparam int unsigned QUIET_CYCLES  = (CLK_HZ / 1000) * QUIET_TIME_MS;
  localparam int unsigned QUIET_CNT_W   = 26;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    LED_GREEN  = 2'b00,
    LED_ORANGE = 2'b01,
    LED_RED    = 2'b10
  } ram_led_t;

  typedef enum logic {
    QS_ARMED = 1'b0,
    QS_QUIET = 1'b1
  } ram_qstate_t;

endpackage : ram_pkg

/* File: tb/ram_link_model.sv */
// optical master side: accepts alarm messages, may stall
`timescale 1ns/1ps
module ram_link_model (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // message link
  input wire logic        msg_valid_i,
  input wire logic  [4:0] msg_code_i,
  output logic            msg_ready_o,
  // bench control and record
  input wire logic        stall_i,
  output logic      [4:0] last_code_o,
  output int              got_cnt_o
);
  // ready is a plain level so a stall can last any number of cycles
  assign msg_ready_o = !stall_i;
  // count every accepted message and keep its code
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      got_cnt_o   <= 0;
      last_code_o <= 5'h00;
    end
    else if (msg_valid_i && msg_ready_o)
    begin
      got_cnt_o   <= got_cnt_o + 1;
      last_code_o <= msg_code_i;
    end
  end
endmodule : ram_link_model

/* File: tb/ram_monitor_bench.sv */
// self-checking bench of the remote alarm monitor
`timescale 1ns/1ps
module ram_monitor_bench;
  localparam int QC = 20; // short quiet gap keeps the run brief
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, stall, rdy, msg_valid_o, wb_ack_o;
  logic [7:0] wb_adr;
  logic [31:0] wb_dat, q, wb_dat_o;
  logic [17:0] alm;
  logic [4:0] msg_code_o, code;
  logic led_green_o, led_orange_o, led_red_o, irq_o;
  int got, n, error_cnt, check_count;
  ram_monitor #(.QUIET_CYCLES(QC)) ram_monitor_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .opt_rx_fail_i(alm[0]), .opt_tx_fail_i(alm[1]),
    .autolevel_i(alm[2]), .amp_current_i(alm[5:3]), .alc_downlink_i(alm[6]), .alc_uplink_i(alm[7]),
    .temp_i(alm[8]), .bus_fail_i(alm[9]), .psu_12v_i(alm[10]), .psu_28v_i(alm[11]), .psu_mains_i(alm[12]),
    .fan_i(alm[13]), .ext_alarm_i(alm[17:14]), .msg_valid_o(msg_valid_o), .msg_code_o(msg_code_o),
    .msg_ready_i(rdy), .led_green_o(led_green_o), .led_orange_o(led_orange_o), .led_red_o(led_red_o),
    .irq_o(irq_o));
  ram_link_model ram_link_model_i (.clk_i(clk_i), .rst_i(rst_i), .msg_valid_i(msg_valid_o),
    .msg_code_i(msg_code_o), .msg_ready_o(rdy), .stall_i(stall), .last_code_o(code), .got_cnt_o(got));
  // ******
  // tasks
  // ******
  task automatic test_done;
    if (error_cnt == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      error_cnt++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check
  // one classic cycle; the leading edge keeps strobe low a cycle between requests
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} <= {2'b11, w, a, d};
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 20);
    q = wb_dat_o;
    {wb_cyc, wb_stb, wb_we} <= 3'b000;
    if (k >= 20)
    begin
      check(wb_ack_o, 1);
      test_done();
    end
  endtask : wb
  task automatic wait_msg(input int m);
    int k;
    k = 0;
    while (got < m && k < 200)
    begin
      @(posedge clk_i);
      k++;
    end
    if (got < m)
    begin
      check(got, m);
      test_done();
    end
  endtask : wait_msg
  task automatic idle(input int c);
    repeat (c) @(posedge clk_i);
  endtask : idle
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // ******
  // main sequence
  // ******
  initial
  begin
    {rst_i, wb_cyc, wb_stb, wb_we, stall, wb_adr, wb_dat, alm} = {1'b1, 4'h0, 8'h00, 32'h0, 18'h0};
    error_cnt = 0;
    check_count = 0;
    idle(3);
    rst_i <= 1'b0;
    wb(0, ram_pkg::ADR_LED, 0); check(q, 0);
    check(led_green_o, 1);
    wb(0, ram_pkg::ADR_MASK, 0); check(q, 0);
    wb(0, ram_pkg::ADR_CTRL, 0); check(q, 1);
    wb(1, 8'h14, 32'hFFFF_FFFF); wb(0, 8'h14, 0); check(q, 0);
    wb(1, ram_pkg::ADR_MASK, 32'h3FFFF);
    // every alarm alone: one message, its flag, its led colour
    for (int i = 0; i < 18; i++)
    begin
      alm <= 18'h1 << i;
      n = got + 1;
      wait_msg(n);
      check(code, i);
      wb(0, ram_pkg::ADR_STATUS, 0); check(q, 32'h1 << i);
      wb(0, ram_pkg::ADR_LED, 0); check(q, ram_pkg::RED_GROUP[i] ? 2 : 1);
      wb(0, ram_pkg::ADR_EVENT, 0); check(q, 32'h1 << i);
      check(irq_o, 1);
      alm <= 18'h0;
      wb(1, ram_pkg::ADR_EVENT, 32'h1 << i);
      wb(0, ram_pkg::ADR_EVENT, 0); check(q, 0);
      idle(QC + 8);
      check(led_green_o, 1);
      check(got, n);
    end
    // stalled link holds the message, then no repeat without a full quiet gap
    stall <= 1'b1;
    alm <= 18'h2;
    n = got + 1;
    idle(15);
    check(msg_valid_o, 1);
    stall <= 1'b0;
    wait_msg(n);
    check(code, 1);
    idle(40);
    alm <= 18'h0;
    idle(12);
    alm <= 18'h2;
    idle(3);
    alm <= 18'h0;
    idle(12);
    alm <= 18'h2;
    idle(30);
    check(got, n);
    alm <= 18'h0;
    idle(QC + 8);
    alm <= 18'h2;
    wait_msg(n + 1);
    check(code, 1);
    // masking and clearing the interrupt
    wb(1, ram_pkg::ADR_MASK, 0);
    idle(1);
    check(irq_o, 0);
    wb(1, ram_pkg::ADR_MASK, 32'h2);
    idle(1);
    check(irq_o, 1);
    wb(1, ram_pkg::ADR_EVENT, 32'h2);
    idle(1);
    check(irq_o, 0);
    // supply and external alarm together
    alm <= 18'h04800;
    wait_msg(n + 3);
    idle(4);
    check({led_red_o, led_orange_o}, 2'b10);
    wb(0, ram_pkg::ADR_LED, 0); check(q, 2);
    // messages switched off: the alarm still marks its event but nothing leaves on the link
    wb(1, ram_pkg::ADR_CTRL, 0);
    alm <= 18'h04A00;
    idle(12);
    check(got, n + 3);
    check(msg_valid_o, 0);
    wb(0, ram_pkg::ADR_EVENT, 0); check(q, 32'h04A00);
    wb(1, ram_pkg::ADR_CTRL, 1);
    wb(0, ram_pkg::ADR_CTRL, 0); check(q, 1);
    test_done();
  end
endmodule : ram_monitor_bench

/* File: tb/ram_monitor_properties.sv */
// concurrent checks on the remote alarm monitor ports
`timescale 1ns/1ps
module ram_monitor_properties (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // bus and messages
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       msg_valid_o,
  input wire logic [4:0] msg_code_o,
  input wire logic       msg_ready_i,
  // alarm pins
  input wire logic       opt_rx_fail_i,
  input wire logic       opt_tx_fail_i,
  input wire logic       alc_downlink_i,
  input wire logic       alc_uplink_i,
  input wire logic       temp_i,
  input wire logic       psu_12v_i,
  input wire logic       psu_28v_i,
  input wire logic       fan_i,
  input wire logic [3:0] ext_alarm_i,
  // led and interrupt
  input wire logic       led_green_o,
  input wire logic       led_orange_o,
  input wire logic       led_red_o,
  input wire logic       irq_o
);
  // ******
  // led groups
  // ******
  wire red_w = psu_12v_i | psu_28v_i | temp_i | fan_i;
  wire orn_w = (|ext_alarm_i) | opt_rx_fail_i | alc_downlink_i | alc_uplink_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // four equal samples cover the two sync flops and the led register
  chk_led_onehot: assert property ($onehot({led_green_o, led_orange_o, led_red_o}))
    else $error("led not one-hot");
  chk_led_not_green: assert property ((red_w | orn_w)[*4] |-> !led_green_o)
    else $error("green led with alarm");
  chk_led_orange_on: assert property ((orn_w && !red_w)[*4] |-> led_orange_o)
    else $error("orange led missing");
  chk_led_red_on: assert property (red_w[*4] |-> led_red_o)
    else $error("red led missing");
  chk_red_over_orange: assert property ((red_w && orn_w)[*4] |-> led_red_o && !led_orange_o)
    else $error("red does not win");
  chk_bus_ack_once: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single pulse");
  chk_msg_held: assert property (msg_valid_o && !msg_ready_i |=> msg_valid_o && $stable(msg_code_o))
    else $error("message dropped before accept");
  // a steady alarm must not yield a second message once accepted
  chk_no_repeat_msg: assert property (opt_tx_fail_i[*8] ##0 (msg_valid_o && msg_ready_i && msg_code_o == 5'h01)
    ##1 opt_tx_fail_i[*8] |-> !(msg_valid_o && msg_code_o == 5'h01))
    else $error("message repeated");
  cov_msg_taken: cover property (msg_valid_o && msg_ready_i);
  cov_red_both: cover property (led_red_o && orn_w);
  cov_irq_high: cover property (irq_o);
endmodule : ram_monitor_properties

bind ram_monitor ram_monitor_properties ram_monitor_properties_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .msg_valid_o, .msg_code_o, .msg_ready_i, .opt_rx_fail_i, .opt_tx_fail_i, .alc_downlink_i,
  .alc_uplink_i, .temp_i, .psu_12v_i, .psu_28v_i, .fan_i, .ext_alarm_i, .led_green_o, .led_orange_o,
  .led_red_o, .irq_o);
